// ==== pkg/timer_consts.svh ====
// Register offsets, field positions, sizes and reset values of the timer block.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 12'h000
`define OFS_CHMODE 12'h004
`define OFS_EDGE 12'h008
`define OFS_COUNT 12'h00C
`define OFS_STATUS 12'h010
`define OFS_IRQ_EN 12'h014
`define OFS_IRQ_CLR 12'h018
`define OFS_ACC 12'h01C
`define OFS_CH0 12'h020

// ****************************************
// Control fields
// ****************************************
`define CTRL_EN_BIT 0
`define CTRL_PRE_LSB 1
`define CTRL_ACC_EN_BIT 4
`define CTRL_ACC_GATED_BIT 5
`define CTRL_ACC_POL_BIT 6

// ****************************************
// Status bit positions
// ****************************************
`define ST_CH_LSB 0
`define ST_OVF_BIT 4
`define ST_ACC_OVF_BIT 5
`define ST_WIDTH 6

// ****************************************
// Sizes and reset values
// ****************************************
`define PRESCALE_STAGES 7
`define RESET_WORD 32'h0000_0000

`endif

// ==== pkg/timer_pkg.sv ====
// Types shared by the timer block files.
package timer_pkg;

	// Per channel function choice.
	typedef enum logic [1:0] {
		CH_OFF = 2'h0,
		CH_CAPTURE = 2'h1,
		CH_COMPARE = 2'h2
	} ch_mode_t;

	// Capture edge choice; for compare, the pin action.
	typedef logic [1:0] edge_sel_t;

	// Bus access state, one-hot.
	typedef enum logic [1:0] {
		BUS_SETUP = 2'b01,
		BUS_ACCESS = 2'b10
	} bus_state_t;

	// Event bundle from the channel bank.
	typedef struct packed {
		logic [3:0] chan;
		logic ovf;
		logic acc_ovf;
	} timer_events_t;

endpackage

// ==== design/timer_prescaler.sv ====
// Seven-stage prescaler giving a one-cycle tick enable for the counter.
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_prescaler
	import timer_pkg::*;
#(
	parameter int STAGES = `PRESCALE_STAGES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic [2:0] stage_sel,
	// Output
	output logic tick
);

	typedef struct packed {
		logic [STAGES-1:0] div;
		logic tick;
	} pre_state_t;

	pre_state_t st;
	pre_state_t next_st;
	logic [STAGES:0] carry;

	// ****************************************
	// Ripple carries of each binary stage
	// ****************************************
	// Stage k carries out when all lower stages and itself are at one.
	assign carry[0] = run;
	genvar k;
	generate
		for (k = 0; k < STAGES; k++) begin : g_stage
			assign carry[k+1] = carry[k] & st.div[k];
		end
	endgenerate

	// ****************************************
	// Next state
	// ****************************************
	// Select zero passes every clock; select n divides by two to the n.
	always_comb begin
		next_st = st;
		if (run) begin
			next_st.div = st.div + {{(STAGES-1){1'b0}}, 1'b1};
		end
		if (stage_sel == 3'h0) begin
			next_st.tick = run;
		end else begin
			next_st.tick = carry[stage_sel];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule

// ==== design/timer_pin_sync.sv ====
// Two-flop synchronisers for the four timer pins.
`timescale 1ns/1ps
module timer_pin_sync
	import timer_pkg::*;
#(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and result
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// ****************************************
	// Two stages
	// ****************************************
	// Only the second stage reads the first, so metastability never spreads.
	always_comb begin
		next_st.meta = pin_async;
		next_st.stable = st.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pin_sync = st.stable;

endmodule

// ==== design/general_timer_block.sv ====
// Four-channel capture/compare timer with pulse accumulator and APB registers.
`timescale 1ns/1ps
`include "timer_consts.svh"

module general_timer_block
	import timer_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pins
	input wire logic [3:0] timer_channel_pins_in,
	output logic [3:0] timer_channel_pins_out,
	output logic [3:0] timer_channel_pins_oe,
	// Interrupt
	output logic irq
);

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [6:0] ctrl;
		logic [7:0] chmode;
		logic [7:0] edges;
		logic [15:0] count;
		logic [15:0] acc;
		logic [`ST_WIDTH-1:0] status;
		logic [`ST_WIDTH-1:0] irq_en;
		logic [3:0][15:0] chval;
		logic [3:0] pin_prev;
		logic [3:0] pin_out;
		logic [3:0] pin_oe;
		logic irq;
	} top_state_t;

	top_state_t st;
	top_state_t next_st;
	logic tick;
	logic [3:0] pin_s;
	logic [3:0] cap_hit;
	logic [3:0] cmp_hit;
	logic acc_mode;
	logic acc_gate;
	logic acc_step;
	logic wr_ok;
	logic rd_ok;
	logic [3:0] ch_sel;
	logic ch_addr;
	timer_events_t ev;

	// ****************************************
	// Submodules
	// ****************************************
	timer_prescaler #(.STAGES(`PRESCALE_STAGES)) u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.run(st.ctrl[`CTRL_EN_BIT]),
		.stage_sel(st.ctrl[`CTRL_PRE_LSB +: 3]),
		.tick(tick)
	);

	timer_pin_sync #(.WIDTH(4)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_async(timer_channel_pins_in),
		.pin_sync(pin_s)
	);

	// ****************************************
	// Channel event detection
	// ****************************************
	// Every channel is examined in parallel, so capture and compare coexist.
	genvar c;
	generate
		for (c = 0; c < 4; c++) begin : g_ch
			logic rise;
			logic fall;
			logic own;
			assign own = !(c == 3 && acc_mode);
			assign rise = pin_s[c] & ~st.pin_prev[c];
			assign fall = ~pin_s[c] & st.pin_prev[c];
			// Edge code: 1 rising, 2 falling, 3 both.
			assign cap_hit[c] = own && st.chmode[2*c +: 2] == CH_CAPTURE &&
				((st.edges[2*c] & rise) | (st.edges[2*c+1] & fall));
			assign cmp_hit[c] = own && st.chmode[2*c +: 2] == CH_COMPARE && tick &&
				st.count == st.chval[c];
		end
	endgenerate

	// Accumulator input is channel three's pin, polarity selected for both gated time and event edges.
	assign acc_mode = st.ctrl[`CTRL_ACC_EN_BIT];
	assign acc_gate = pin_s[3] ^ st.ctrl[`CTRL_ACC_POL_BIT];
	assign acc_step = acc_mode && (st.ctrl[`CTRL_ACC_GATED_BIT] ? (acc_gate && tick)
		: (acc_gate && !(st.pin_prev[3] ^ st.ctrl[`CTRL_ACC_POL_BIT])));

	assign ev.chan = cap_hit | cmp_hit;
	assign ev.ovf = tick && st.count == 16'hFFFF;
	assign ev.acc_ovf = acc_step && st.acc == 16'hFFFF;

	// ****************************************
	// APB decode
	// ****************************************
	assign wr_ok = psel && penable && pwrite && !st.pready;
	assign rd_ok = psel && !penable;
	assign ch_addr = paddr[11:4] == 8'h02;
	assign ch_sel = ch_addr ? (4'h1 << paddr[3:2]) : 4'h0;

	// ****************************************
	// Next state
	// ****************************************
	// One wait state: setup, then access answered with pready a cycle later.
	always_comb begin
		next_st = st;
		next_st.pready = psel && penable && !st.pready;
		next_st.pslverr = 1'b0;
		next_st.pin_prev = pin_s;

		// Counter advances only on the prescaler tick and wraps naturally.
		if (tick) begin
			next_st.count = st.count + 16'h0001;
		end
		if (acc_step) begin
			next_st.acc = st.acc + 16'h0001;
		end

		// Capture latches the counter; compare drives the pin per its action code.
		for (int i = 0; i < 4; i++) begin
			if (cap_hit[i]) begin
				next_st.chval[i] = st.count;
			end
			next_st.pin_oe[i] = st.chmode[2*i +: 2] == CH_COMPARE &&
				!(i == 3 && acc_mode);
			if (cmp_hit[i]) begin
				case (st.edges[2*i +: 2])
					2'h1: next_st.pin_out[i] = ~st.pin_out[i];
					2'h2: next_st.pin_out[i] = 1'b0;
					2'h3: next_st.pin_out[i] = 1'b1;
					default: next_st.pin_out[i] = st.pin_out[i];
				endcase
			end
		end

		// Register writes take effect at the edge that raises pready, a cycle before the access completes.
		if (wr_ok) begin
			case (paddr)
				`OFS_CTRL: next_st.ctrl = pwdata[6:0];
				`OFS_CHMODE: next_st.chmode = pwdata[7:0];
				`OFS_EDGE: next_st.edges = pwdata[7:0];
				`OFS_COUNT: next_st.count = pwdata[15:0];
				`OFS_ACC: next_st.acc = pwdata[15:0];
				`OFS_IRQ_EN: next_st.irq_en = pwdata[`ST_WIDTH-1:0];
				`OFS_IRQ_CLR: next_st.status = st.status & ~pwdata[`ST_WIDTH-1:0];
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (ch_sel[i]) begin
							next_st.chval[i] = pwdata[15:0];
						end
					end
				end
			endcase
		end

		// Hardware sets after the clear, so a same-cycle event is kept.
		next_st.status = next_st.status | {ev.acc_ovf, ev.ovf, ev.chan};

		// Read data is formed during setup and held through the access phase.
		if (rd_ok) begin
			case (paddr)
				`OFS_CTRL: next_st.prdata = {25'h0, st.ctrl};
				`OFS_CHMODE: next_st.prdata = {24'h0, st.chmode};
				`OFS_EDGE: next_st.prdata = {24'h0, st.edges};
				`OFS_COUNT: next_st.prdata = {16'h0, st.count};
				`OFS_ACC: next_st.prdata = {16'h0, st.acc};
				`OFS_STATUS: next_st.prdata = {26'h0, st.status};
				`OFS_IRQ_EN: next_st.prdata = {26'h0, st.irq_en};
				default: begin
					next_st.prdata = `RESET_WORD;
					for (int i = 0; i < 4; i++) begin
						if (ch_sel[i]) begin
							next_st.prdata = {16'h0, st.chval[i]};
						end
					end
				end
			endcase
		end

		next_st.irq = |(next_st.status & next_st.irq_en);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign timer_channel_pins_out = st.pin_out;
	assign timer_channel_pins_oe = st.pin_oe;
	assign irq = st.irq;

	// ****************************************
	// Checks
	// ****************************************
	a_count_tick: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !wr_ok |=> st.count == $past(st.count) + 16'h0001)
		else $error("Counter did not step on tick.");
	a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!tick && !wr_ok |=> $stable(st.count))
		else $error("Counter moved without tick.");
	a_capture_value: assert property (@(posedge pclk) disable iff (!presetn)
		cap_hit[0] |=> st.chval[0] == $past(st.count))
		else $error("Capture missed counter value.");
	a_ovf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		ev.ovf |=> st.status[`ST_OVF_BIT])
		else $error("Overflow flag not set.");
	a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
		st.status[0] && !wr_ok |=> st.status[0])
		else $error("Status flag dropped without clear.");
	a_cmp_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		cmp_hit[1] && st.edges[3:2] == 2'h1 |=> st.pin_out[1] != $past(st.pin_out[1]))
		else $error("Compare did not toggle pin.");
	a_pin_dir: assert property (@(posedge pclk) disable iff (!presetn)
		st.chmode[1:0] == CH_CAPTURE |=> !st.pin_oe[0])
		else $error("Capture pin driven.");
	a_acc_step: assert property (@(posedge pclk) disable iff (!presetn)
		acc_step && !wr_ok |=> st.acc == $past(st.acc) + 16'h0001)
		else $error("Accumulator did not step.");
	a_acc_owns: assert property (@(posedge pclk) disable iff (!presetn)
		acc_mode |-> !cap_hit[3] && !cmp_hit[3])
		else $error("Channel three active in accumulator mode.");
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		|(st.status & st.irq_en) |-> st.irq)
		else $error("Interrupt not raised.");

endmodule

// ==== tb/timer_pin_partner.sv ====
// Far-side model of the four timer pins: waveform sources and loads.
`timescale 1ns/1ps
module timer_pin_partner (
	// Design pin side
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	// Source levels wanted by the bench
	input wire logic [3:0] source,
	// Resolved wire levels
	output logic [3:0] pin_level
);
	// A driven pin shows the design's value; otherwise the external source wins.
	// Sources never fight an enabled output, so no contention is modelled.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level[i] = pin_oe[i] ? pin_out[i] : source[i];
		end
	end
endmodule

// ==== tb/test_general_timer_block.sv ====
// Self-checking bench for the four-channel timer block.
`timescale 1ns/1ps
`include "timer_consts.svh"
module test_general_timer_block;
	import timer_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] pin_out;
	logic [3:0] pin_oe;
	logic [3:0] pin_level;
	logic [3:0] source = 4'h0;
	logic irq;
	logic [31:0] rd;
	logic [31:0] lo;
	logic [31:0] hi;
	int fail_count = 0;
	int total_checks = 0;

	// Clock at 25 MHz.
	always #20 pclk = ~pclk;

	general_timer_block uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_channel_pins_in(pin_level),
		.timer_channel_pins_out(pin_out), .timer_channel_pins_oe(pin_oe), .irq(irq));

	timer_pin_partner far_side (.pin_out(pin_out), .pin_oe(pin_oe), .source(source),
		.pin_level(pin_level));

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	// One APB transfer; the wait for pready is bounded only by the watchdog.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		chk({31'h0, pslverr}, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// A value that may move by a few counts with bus timing is judged in a window.
	task automatic chk_rng(input logic [31:0] got, input logic [31:0] l, input logic [31:0] h);
		total_checks++;
		if ($isunknown(got) || got < l || got > h) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, l, h);
		end
	endtask

	task automatic stop_test;
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	// Reset values read back zero; an unmapped place ignores writes.
	task automatic t_reset;
		apb(1'b0, `OFS_CTRL, 32'h0);
		chk(rd, `RESET_WORD);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, `RESET_WORD);
		apb(1'b1, 12'h040, 32'hFFFF_FFFF);
		apb(1'b0, 12'h040, 32'h0);
		chk(rd, 32'h0000_0000);
	endtask

	// Channel 0 captures a rising edge while channel 1 sets its pin on match.
	task automatic t_cap_cmp;
		apb(1'b1, `OFS_CH0 + 12'h004, 32'h0000_0040);
		apb(1'b1, `OFS_CHMODE, 32'h0000_0009);
		apb(1'b1, `OFS_EDGE, 32'h0000_000D);
		apb(1'b1, `OFS_COUNT, 32'h0);
		apb(1'b1, `OFS_CTRL, 32'h0000_0001);
		chk({31'h0, pin_level[1]}, 32'h0);
		apb(1'b0, `OFS_COUNT, 32'h0);
		lo = rd;
		source[0] <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, `OFS_COUNT, 32'h0);
		hi = rd;
		apb(1'b0, `OFS_CH0, 32'h0);
		chk_rng(rd, lo, hi);
		repeat (80) @(posedge pclk);
		chk({28'h0, pin_oe}, 32'h0000_0002);
		chk({31'h0, pin_level[1]}, 32'h1);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0000_0003);
	endtask

	// Counter wrap is flagged, masked, raises the interrupt and is cleared.
	task automatic t_wrap;
		apb(1'b1, `OFS_CHMODE, 32'h0);
		apb(1'b1, `OFS_IRQ_CLR, 32'h0000_003F);
		apb(1'b1, `OFS_COUNT, 32'h0000_FFF0);
		repeat (40) @(posedge pclk);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0000_0010);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `OFS_IRQ_EN, 32'h0000_0010);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `OFS_CTRL, 32'h0);
		apb(1'b1, `OFS_IRQ_CLR, 32'h0000_003F);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask

	// Prescale select 2 divides the clock by four.
	task automatic t_prescale;
		apb(1'b1, `OFS_CTRL, 32'h0000_0005);
		apb(1'b0, `OFS_COUNT, 32'h0);
		lo = rd;
		repeat (400) @(posedge pclk);
		apb(1'b0, `OFS_COUNT, 32'h0);
		chk_rng(rd - lo, 32'd99, 32'd103);
		apb(1'b1, `OFS_CTRL, 32'h0);
	endtask

	// Event mode counts five rising edges on pin 3.
	task automatic t_accum;
		apb(1'b1, `OFS_ACC, 32'h0);
		apb(1'b1, `OFS_CTRL, 32'h0000_0010);
		repeat (5) begin
			repeat (4) @(posedge pclk);
			source[3] <= 1'b1;
			repeat (4) @(posedge pclk);
			source[3] <= 1'b0;
		end
		repeat (6) @(posedge pclk);
		apb(1'b0, `OFS_ACC, 32'h0);
		chk(rd, 32'h0000_0005);
	endtask

	// Falling capture, toggle and clear actions, and gated inverted accumulation.
	task automatic t_modes;
		apb(1'b1, `OFS_CTRL, 32'h0);
		apb(1'b1, `OFS_CH0 + 12'h004, 32'h0000_0040);
		apb(1'b1, `OFS_EDGE, 32'h0000_0006);
		apb(1'b1, `OFS_CHMODE, 32'h0000_0009);
		apb(1'b1, `OFS_COUNT, 32'h0);
		apb(1'b1, `OFS_ACC, 32'h0);
		apb(1'b1, `OFS_IRQ_CLR, 32'h0000_003F);
		apb(1'b1, `OFS_CTRL, 32'h0000_0071);
		chk({31'h0, pin_level[1]}, 32'h1);
		apb(1'b0, `OFS_COUNT, 32'h0);
		lo = rd;
		source[0] <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b0, `OFS_COUNT, 32'h0);
		hi = rd;
		apb(1'b0, `OFS_CH0, 32'h0);
		chk_rng(rd, lo, hi);
		// With inverted polarity a high pin closes the gate after the synchroniser delay.
		apb(1'b0, `OFS_ACC, 32'h0);
		lo = rd;
		chk_rng(lo, 32'h0000_0001, 32'h0000_FFFF);
		source[3] <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, `OFS_ACC, 32'h0);
		chk_rng(rd - lo, 32'd4, 32'd6);
		source[3] <= 1'b0;
		repeat (80) @(posedge pclk);
		chk({31'h0, pin_level[1]}, 32'h0);
		apb(1'b1, `OFS_COUNT, 32'h0);
		repeat (80) @(posedge pclk);
		chk({31'h0, pin_level[1]}, 32'h1);
		apb(1'b1, `OFS_EDGE, 32'h0000_000A);
		apb(1'b1, `OFS_COUNT, 32'h0);
		repeat (80) @(posedge pclk);
		chk({31'h0, pin_level[1]}, 32'h0);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0000_0003);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `OFS_CTRL, 32'h0);
	endtask

	// Watchdog, far beyond the thousand or so cycles the scenarios need.
	initial begin
		#800000;
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_cap_cmp();
		t_wrap();
		t_prescale();
		t_accum();
		t_modes();
		stop_test();
	end
endmodule
